/* rtl/rsb_top.sv */
// Purpose: reset sources, brown-out control and reset cause register
// Assumes: analog detectors give raw levels; APB slave on ref_clk
// Notes: power-up timer tick comes from the internal rc clock domain
//
// Contract
// - watchdog timeout flag set on power-up, clear-watchdog, sleep.
// - power-on flag cleared on each power-on reset, else changed only by software write.
// - only a software write may set the power-on flag.
// - reset held while enabled master clear pin is low.
// - short low glitches on master clear are filtered out.
// - master clear pin is never driven by the device.
// - disabled master clear acts as digital input only, read inverted (high while the pin is low).
// - supply-rise detector produces a power-on reset pulse.
// - brown-out off in mode 00, always active in mode 11.
// - threshold chosen by the two-bit threshold select field.
// - low supply beyond minimum time resets until supply recovers.
// - enabled power-up timer extends reset after supply recovery.
// - brown-out during power-up count restarts the full delay.
// - brown-out enable and power-up timer enable are independent.
// - software brown-out enable works only in mode 01.
// - mode 10 disables brown-out in sleep, enables elsewhere.
// - power-up timer is 11-bit, clocked by internal rc tick.
`timescale 1ns/1ns
module rsb_top
  import rsb_pkg::*;
#(
  parameter int GLITCH_CYC = RSB_GLITCH_CYC,
  parameter int BOR_CYC = RSB_BOR_CYC,
  parameter logic [10:0] POWERUP_TIMER_LEN = RSB_POWERUP_TIMER_MAX
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog detectors and pins
  input wire logic por_det,
  input wire logic bor_low_det,
  input wire logic master_clear_pin_pin,
  input wire logic rc_tick,
  // core events
  input wire logic clear_watchdog_instruction_evt,
  input wire logic sleep_evt,
  input wire logic in_sleep,
  input wire logic wdt_timeout_evt,
  input wire logic reset_instr_evt,
  // outputs
  output logic [1:0] brownout_threshold_select,
  output logic bor_det_en,
  output logic master_clear_pin_digital_in,
  output logic sys_rst_n
);
  default clocking ast_cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // ***********************************************************
  // synchronisers and master clear filter
  // ***********************************************************
  logic [3:0] raw_s;
  logic master_clear_pin_s;
  logic bor_s;
  logic tick_s;
  logic por_s;
  logic master_clear_pin_low_f;
  logic master_clear_pin_enable;

  rsb_sync #(.W(4)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in({rc_tick, bor_low_det, por_det, ~master_clear_pin_pin}),
    .sync_out(raw_s)
  );
  assign master_clear_pin_s = raw_s[0];
  assign por_s = raw_s[1];
  assign bor_s = raw_s[2];
  assign tick_s = raw_s[3];

  rsb_filt #(.CNT(GLITCH_CYC)) u_master_clear_pin_filt (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .lvl_low(master_clear_pin_s),
    .held_low(master_clear_pin_low_f)
  );

  // ***********************************************************
  // configuration register
  // ***********************************************************
  logic [7:0] cfg_q;
  logic [1:0] mode;
  logic pwrte;
  logic wr_en;
  logic rd_en;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign mode = cfg_q[RSB_CFG_MODE_LSB +: 2];
  assign pwrte = cfg_q[RSB_CFG_PWRTE];
  assign master_clear_pin_enable = cfg_q[RSB_CFG_MASTER_CLEAR_PIN_ENABLE];

  // configuration write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= RSB_CFG_RESET;
    end else if (wr_en && paddr == RSB_ADDR_CFG) begin
      cfg_q <= pwdata[7:0];
    end
  end

  assign brownout_threshold_select = cfg_q[RSB_CFG_THR_LSB +: 2];
  assign master_clear_pin_digital_in = master_clear_pin_s;

  // ***********************************************************
  // brown-out enable and detection
  // ***********************************************************
  logic software_brownout_enable_q;
  logic bor_act;
  logic [$clog2(BOR_CYC + 1)-1:0] bor_cnt_q;
  logic bor_hit;
  logic bor_rst_q;

  always_comb begin
    unique case (mode)
      RSB_MODE_OFF: bor_act = 1'b0;
      RSB_MODE_SW: bor_act = software_brownout_enable_q;
      RSB_MODE_NOSLP: bor_act = !in_sleep;
      default: bor_act = 1'b1;
    endcase
  end
  assign bor_det_en = bor_act;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bor_cnt_q <= '0;
    end else if (!(bor_s && bor_act)) begin
      bor_cnt_q <= '0;
    end else if (!bor_hit) begin
      bor_cnt_q <= bor_cnt_q + 1'b1;
    end
  end
  assign bor_hit = (bor_cnt_q == ($clog2(BOR_CYC + 1))'(BOR_CYC));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bor_rst_q <= 1'b0;
    end else if (bor_hit) begin
      bor_rst_q <= 1'b1;
    end else if (!bor_s || !bor_act) begin
      bor_rst_q <= 1'b0;
    end
  end

  // ***********************************************************
  // power-up timer
  // ***********************************************************
  logic [RSB_POWERUP_TIMER_BITS-1:0] powerup_timer_q;
  logic tick_d1_q;
  logic tick_rise;
  logic powerup_timer_busy;
  logic por_d1_q;
  logic por_pulse;

  // rc tick edge, read from synchronised copy
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_d1_q <= 1'b0;
      por_d1_q <= 1'b0;
    end else begin
      tick_d1_q <= tick_s;
      por_d1_q <= por_s;
    end
  end
  assign tick_rise = tick_s && !tick_d1_q;
  assign por_pulse = por_s && !por_d1_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      powerup_timer_q <= '0;
    end else if (por_s || bor_rst_q) begin
      powerup_timer_q <= pwrte ? POWERUP_TIMER_LEN : '0;
    end else if (powerup_timer_q != '0 && tick_rise) begin
      powerup_timer_q <= powerup_timer_q - 1'b1;
    end
  end
  assign powerup_timer_busy = (powerup_timer_q != '0);

  // ***********************************************************
  // reset combine
  // ***********************************************************
  logic rst_req;
  logic [1:0] rel_q;

  assign rst_req = por_s || por_pulse || bor_rst_q || powerup_timer_busy ||
                   (master_clear_pin_enable && master_clear_pin_low_f);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rel_q <= '0;
    end else if (rst_req) begin
      rel_q <= '0;
    end else begin
      rel_q <= {rel_q[0], 1'b1};
    end
  end
  assign sys_rst_n = rel_q[1] && !rst_req;
  // no drive: master clear is input only, no output enable exists

  // ***********************************************************
  // reset cause register
  // ***********************************************************
  logic ipen_q, ri_q, wto_q, pd_q, porf_q, borf_q;
  logic [7:0] cause_rd;
  logic cause_wr;
  assign cause_wr = wr_en && paddr == RSB_ADDR_CAUSE;

  // ipen and ri bits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ipen_q <= 1'b0;
      ri_q <= 1'b1;
    end else begin
      if (cause_wr) begin
        ipen_q <= pwdata[RSB_BIT_IPEN];
      end
      if (reset_instr_evt) begin
        ri_q <= 1'b0;
      end else if (cause_wr) begin
        ri_q <= pwdata[RSB_BIT_RI];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wto_q <= 1'b1;
    end else if (por_pulse || clear_watchdog_instruction_evt || sleep_evt) begin
      wto_q <= 1'b1;
    end else if (wdt_timeout_evt) begin
      wto_q <= 1'b0;
    end
  end

  // power-down flag: set at power-up and clear_watchdog_instruction, cleared by sleep
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pd_q <= 1'b1;
    end else if (por_pulse || clear_watchdog_instruction_evt) begin
      pd_q <= 1'b1;
    end else if (sleep_evt) begin
      pd_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      porf_q <= 1'b0;
    end else if (por_pulse) begin
      porf_q <= 1'b0;
    end else if (cause_wr) begin
      porf_q <= pwdata[RSB_BIT_POR];
    end
  end

  // brown-out flag cleared by brown-out or power-on
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      borf_q <= 1'b0;
    end else if (por_pulse || bor_hit) begin
      borf_q <= 1'b0;
    end else if (cause_wr) begin
      borf_q <= pwdata[RSB_BIT_BOR];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      software_brownout_enable_q <= 1'b1;
    end else if (cause_wr) begin
      software_brownout_enable_q <= pwdata[RSB_BIT_SBOR];
    end
  end

  // bit 5 zero, software enable seen only in mode 01
  assign cause_rd = {ipen_q, (mode == RSB_MODE_SW) && software_brownout_enable_q, 1'b0, ri_q,
                     wto_q, pd_q, porf_q, borf_q};

  // ***********************************************************
  // apb read and answer
  // ***********************************************************
  logic hit;

  assign hit = paddr == RSB_ADDR_CAUSE || paddr == RSB_ADDR_CFG ||
               paddr == RSB_ADDR_STAT;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // registered read data
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        RSB_ADDR_CAUSE: prdata <= {24'h000000, cause_rd};
        RSB_ADDR_CFG: prdata <= {24'h000000, cfg_q};
        RSB_ADDR_STAT: prdata <= {16'h0000, 2'h0, bor_rst_q, bor_act,
                                  sys_rst_n, powerup_timer_q};
        default: prdata <= '0;
      endcase
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  AST_POR_CLR: assert property (
    por_pulse |=> !cause_rd[RSB_BIT_POR])
    else $error("power-on flag not cleared");
  AST_POR_NOSET: assert property (
    $rose(cause_rd[RSB_BIT_POR]) |-> $past(cause_wr))
    else $error("power-on flag set without write");
  AST_WTO_SET: assert property (
    clear_watchdog_instruction_evt || sleep_evt |=> cause_rd[RSB_BIT_WTO])
    else $error("timeout flag not set");
  AST_MASTER_CLEAR_PIN_RST: assert property (master_clear_pin_enable && master_clear_pin_low_f |-> !sys_rst_n)
    else $error("master clear did not reset");
  AST_MASTER_CLEAR_PIN_OFF: assert property (
    !master_clear_pin_enable && rel_q[1] && !por_s && !bor_rst_q && !powerup_timer_busy |-> sys_rst_n)
    else $error("disabled pin caused reset");
  AST_BOR_OFF: assert property (mode == RSB_MODE_OFF |-> !bor_act)
    else $error("brown-out active in mode 00");
  AST_BOR_SLP: assert property (
    mode == RSB_MODE_NOSLP |-> bor_act == !in_sleep)
    else $error("sleep mode gating wrong");
  AST_SBOR_RD: assert property (
    mode != RSB_MODE_SW |-> !cause_rd[RSB_BIT_SBOR])
    else $error("software enable visible outside mode 01");
  AST_POWERUP_TIMER_RLD: assert property (
    bor_rst_q && pwrte |=> powerup_timer_q == POWERUP_TIMER_LEN)
    else $error("power-up timer not reloaded");
  AST_POWERUP_TIMER_HOLD: assert property (powerup_timer_busy |-> !sys_rst_n)
    else $error("released while power-up timer busy");
  AST_REL_SYNC: assert property (
    $rose(sys_rst_n) |-> !$past(rst_req, 2) && !$past(rst_req))
    else $error("release not synchronised");
endmodule

/* rtl/rsb_pkg.sv */
// Purpose: shared constants for the reset source and brown-out block
// Assumes: APB register map, 32-bit data, one aligned word per register
// Notes: all offsets are byte addresses
package rsb_pkg;
  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] RSB_ADDR_CAUSE = 8'h00;
  localparam logic [7:0] RSB_ADDR_CFG = 8'h04;
  localparam logic [7:0] RSB_ADDR_STAT = 8'h08;
  // ***********************************************************
  // cause register bits
  // ***********************************************************
  localparam int RSB_BIT_BOR = 0;
  localparam int RSB_BIT_POR = 1;
  localparam int RSB_BIT_PD = 2;
  localparam int RSB_BIT_WTO = 3;
  localparam int RSB_BIT_RI = 4;
  localparam int RSB_BIT_SBOR = 6;
  localparam int RSB_BIT_IPEN = 7;
  // ***********************************************************
  // configuration fields (cfg register)
  // ***********************************************************
  localparam int RSB_CFG_MODE_LSB = 0;
  localparam int RSB_CFG_THR_LSB = 2;
  localparam int RSB_CFG_MASTER_CLEAR_PIN_ENABLE = 4;
  localparam int RSB_CFG_PWRTE = 5;
  localparam logic [7:0] RSB_CFG_RESET = 8'h31;
  // ***********************************************************
  // brown-out modes
  // ***********************************************************
  localparam logic [1:0] RSB_MODE_OFF = 2'h0;
  localparam logic [1:0] RSB_MODE_SW = 2'h1;
  localparam logic [1:0] RSB_MODE_NOSLP = 2'h2;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int RSB_CLK_MHZ = 250;
  localparam int RSB_GLITCH_NS = 200;
  localparam int RSB_GLITCH_CYC = (RSB_GLITCH_NS * RSB_CLK_MHZ) / 1000;
  localparam int RSB_BOR_NS = 200;
  localparam int RSB_BOR_CYC = (RSB_BOR_NS * RSB_CLK_MHZ + 999) / 1000;
  localparam int RSB_POWERUP_TIMER_BITS = 11;
  localparam logic [10:0] RSB_POWERUP_TIMER_MAX = 11'h7FF;
endpackage

/* rtl/rsb_sync.sv */
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: destination clock ref_clk
// Notes: first stage read only by second stage
`timescale 1ns/1ns
module rsb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // two stage capture
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* rtl/rsb_filt.sv */
// Purpose: low-level persistence filter
// Assumes: input already synchronised
// Notes: output asserts only after CNT consecutive low cycles
`timescale 1ns/1ns
module rsb_filt #(
  parameter int CNT = 50
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // level in, qualified low out
  input wire logic lvl_low,
  output logic held_low
);
  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] CMAX = CW'(CNT);
  logic [CW-1:0] cnt_q;

  // count consecutive low cycles
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!lvl_low) begin
      cnt_q <= '0;
    end else if (cnt_q != CMAX) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign held_low = (cnt_q == CMAX);
endmodule

/* testbench/rsb_top_test.sv */
// Purpose: self-checking bench for the reset source and brown-out block
// Assumes: apb answers at once; short counts set by parameters
// Notes: rc tick is a slow level made from the cycle counter
`timescale 1ns/1ns
module rsb_top_test;
  import rsb_pkg::*;
  // ********************************
  // signals
  // ********************************
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic por_det, bor_low_det, master_clear_pin_pin, rc_tick, in_sleep;
  logic clear_watchdog_instruction_evt, sleep_evt, wdt_timeout_evt, reset_instr_evt;
  logic [1:0] thr_sel;
  logic bor_det_en, master_clear_pin_digital_in, sys_rst_n, slv_err;
  int errors, samples_checked;
  int cycles = 0;

  // device with short filter and timer counts
  rsb_top #(.GLITCH_CYC(4), .BOR_CYC(4), .POWERUP_TIMER_LEN(11'h005)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .por_det(por_det),
    .bor_low_det(bor_low_det), .master_clear_pin_pin(master_clear_pin_pin), .rc_tick(rc_tick),
    .clear_watchdog_instruction_evt(clear_watchdog_instruction_evt), .sleep_evt(sleep_evt), .in_sleep(in_sleep),
    .wdt_timeout_evt(wdt_timeout_evt), .reset_instr_evt(reset_instr_evt),
    .brownout_threshold_select(thr_sel), .bor_det_en(bor_det_en),
    .master_clear_pin_digital_in(master_clear_pin_digital_in), .sys_rst_n(sys_rst_n));

  // ********************************
  // clock, rc tick and timeout
  // ********************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // rc tick period is 16 clocks; hang cut after 20000
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    rc_tick <= cycles[3];
    if (cycles == 20000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end

  // ********************************
  // compare and drive tasks
  // ********************************
  task automatic chk_reg(input logic [31:0] g, e, input string m);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, e, input string m);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask

  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    d = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle core event: 0 timeout, 1 sleep, 2 clear, 3 reset instr
  task automatic ev(input int k);
    @(posedge ref_clk);
    wdt_timeout_evt <= (k == 0);
    sleep_evt <= (k == 1);
    clear_watchdog_instruction_evt <= (k == 2);
    reset_instr_evt <= (k == 3);
    @(posedge ref_clk);
    {wdt_timeout_evt, sleep_evt, clear_watchdog_instruction_evt, reset_instr_evt} <= 4'h0;
  endtask

  task automatic wait_lvl(input logic lvl, input int n);
    int i;
    i = 0;
    while (sys_rst_n !== lvl && i < n) begin
      @(posedge ref_clk);
      i++;
    end
    chk_bit(sys_rst_n, lvl, "reset level wait");
  endtask

  task automatic hold(input logic lvl, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      if (sys_rst_n !== lvl) bad = 1'b1;
    end
    chk_bit(bad ? ~lvl : lvl, lvl, "reset level hold");
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset_vals();
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd, 32'h0000005C, "cause reset");
    chk_bit(slv_err, 1'b0, "mapped read no error");
    chk_bit(pready, 1'b1, "ready at once");
    apb(0, RSB_ADDR_CFG, 0, rd);
    chk_reg(rd, 32'h00000031, "cfg reset");
    apb(0, RSB_ADDR_STAT, 0, rd);
    chk_reg(rd, 32'h00001800, "status reset");
    apb(0, 8'h0C, 0, rd);
    chk_bit(slv_err, 1'b1, "unmapped read error");
    chk_reg(rd, 32'h00000000, "unmapped read data");
    apb(1, 8'h10, 32'hFFFFFFFF, rd);
    chk_bit(slv_err, 1'b1, "unmapped write error");
  endtask

  task automatic t_flags();
    apb(1, RSB_ADDR_CAUSE, 32'h000000FF, rd);
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd, 32'h000000DF, "sw set flags");
    ev(0);
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd, 32'h000000D7, "timeout clears flag");
    ev(1);
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd, 32'h000000DB, "sleep sets timeout flag");
    ev(2);
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd, 32'h000000DF, "clear sets timeout flag");
    ev(3);
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd, 32'h000000CF, "reset instr flag");
  endtask

  // every mode, sleep state and software enable; threshold follows mode
  task automatic t_bor_cfg();
    logic [1:0] m;
    logic e;
    for (int i = 0; i < 16; i++) begin
      m = i[3:2];
      apb(1, RSB_ADDR_CFG, {24'h0, 4'h3, m, m}, rd);
      apb(1, RSB_ADDR_CAUSE, i[0] ? 32'hDF : 32'h9F, rd);
      @(posedge ref_clk);
      in_sleep <= i[1];
      repeat (2) @(posedge ref_clk);
      e = (m == 2'h1) ? i[0] : (m == 2'h2) ? ~i[1] : (m == 2'h3);
      chk_bit(bor_det_en, e, "brown-out enable");
      chk_reg({30'h0, thr_sel}, {30'h0, m}, "threshold");
      apb(0, RSB_ADDR_CAUSE, 0, rd);
      chk_bit(rd[6], (m == 2'h1) & i[0], "sw enable read");
    end
    in_sleep <= 1'b0;
  endtask

  // brown-out with and without the power-up timer
  task automatic t_bor(input logic pw);
    apb(1, RSB_ADDR_CFG, pw ? 32'h33 : 32'h13, rd);
    apb(1, RSB_ADDR_CAUSE, 32'hDF, rd);
    bor_low_det <= 1'b1;
    wait_lvl(1'b0, 20);
    hold(1'b0, 30);
    bor_low_det <= 1'b0;
    if (pw) begin
      hold(1'b0, 40);
      bor_low_det <= 1'b1;
      repeat (12) @(posedge ref_clk);
      bor_low_det <= 1'b0;
      hold(1'b0, 60);
      wait_lvl(1'b1, 200);
    end else begin
      wait_lvl(1'b1, 12);
    end
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd & 32'h3, 32'h2, "brown-out cause");
  endtask

  task automatic t_master_clear_pin();
    apb(1, RSB_ADDR_CFG, 32'h13, rd);
    master_clear_pin_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    master_clear_pin_pin <= 1'b1;
    hold(1'b1, 15);
    master_clear_pin_pin <= 1'b0;
    wait_lvl(1'b0, 15);
    hold(1'b0, 30);
    master_clear_pin_pin <= 1'b1;
    wait_lvl(1'b1, 15);
    apb(1, RSB_ADDR_CFG, 32'h03, rd);
    master_clear_pin_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk_bit(master_clear_pin_digital_in, 1'b1, "pin as input low");
    hold(1'b1, 30);
    master_clear_pin_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_bit(master_clear_pin_digital_in, 1'b0, "pin as input high");
  endtask

  task automatic t_por();
    apb(1, RSB_ADDR_CFG, 32'h13, rd);
    apb(1, RSB_ADDR_CAUSE, 32'hDF, rd);
    por_det <= 1'b1;
    wait_lvl(1'b0, 15);
    repeat (5) @(posedge ref_clk);
    por_det <= 1'b0;
    wait_lvl(1'b1, 200);
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd & 32'hF, 32'hC, "power-on cause");
    @(posedge ref_clk);
    nrst <= 1'b0;
    #1 chk_bit(sys_rst_n, 1'b0, "async assert");
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1 chk_bit(sys_rst_n, 1'b0, "sync release");
    wait_lvl(1'b1, 300);
    apb(0, RSB_ADDR_CAUSE, 0, rd);
    chk_reg(rd, 32'h0000005C, "cause after mid-run reset");
  endtask

  // ********************************
  // verdict and main sequence
  // ********************************
  task automatic close_out();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {por_det, bor_low_det, in_sleep} = 3'h0;
    {clear_watchdog_instruction_evt, sleep_evt, wdt_timeout_evt, reset_instr_evt} = 4'h0;
    master_clear_pin_pin = 1'b1;
    errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_lvl(1'b1, 300);
    t_reset_vals();
    t_flags();
    t_bor_cfg();
    t_bor(1'b1);
    t_bor(1'b0);
    t_master_clear_pin();
    t_por();
    close_out();
  end
endmodule
